// file: design/ssdhp_pkg.sv
/*
 package for the split strobe direct host port: pin widths, wait length,
 endian encodings, sync stage count and timing counts. assumes a 40 MHz clk_i.
*/
// Contract
// - low write strobes pick written byte lanes
// - low read strobes pick driven byte lanes
// - little endian: low lane is even byte
// - big endian: high lane is even byte
// - address bit zero ignored, word aligned
// - wait low after write strobe falls, released after
// - wait low after read strobe falls, released after
// - read data valid when wait released
// - no-wait host stretches by wait length
// - no-wait write lasts wait length plus three
// - no-wait read sample after wait plus 29ns
// - select and address stable around strobes
package ssdhp_pkg;
   localparam int          SSDHP_ADDR_W      = 17;    // word address bits 17:1
   localparam int          SSDHP_DATA_W      = 16;
   localparam int          SSDHP_CLK_MHZ     = 40;
   localparam int          SSDHP_CLK_PS      = 25000;
   localparam int          SSDHP_WAIT_LEN    = 4;     // wait length in system clocks
   localparam int          SSDHP_WR_EXTRA    = 3;     // extra clocks on a no-wait write
   localparam int          SSDHP_RD_EXTRA_PS = 29000; // 29 ns after the wait length
   // 29 ns rounded up to whole clocks
   localparam int          SSDHP_RD_EXTRA_CYC =
      (SSDHP_RD_EXTRA_PS + SSDHP_CLK_PS - 1) / SSDHP_CLK_PS;
   localparam int          SSDHP_CNT_W       = 8;
   localparam logic        SSDHP_LITTLE      = 1'h0;
   localparam logic        SSDHP_BIG         = 1'h1;
   localparam int          SSDHP_SYNC_STAGES = 2;
endpackage

// file: design/ssdhp_bus_if.sv
/*
 interface carrying the host port pins between host and device ends.
 resolves wait from wait_oe itself; assumes the bench resolves the data wires from the enables.
*/
`timescale 1ns/1ps
interface ssdhp_bus_if;
   import ssdhp_pkg::*;
   logic                    cs_n;
   logic                    mem_sel;
   logic [SSDHP_ADDR_W-1:0] addr;
   logic                    upper_write_strobe_n;
   logic                    lower_write_strobe_n;
   logic                    upper_read_strobe_n;
   logic                    lower_read_strobe_n;
   logic [SSDHP_DATA_W-1:0] host_d;
   logic                    host_d_oe;
   logic [SSDHP_DATA_W-1:0] dev_d;
   logic [1:0]              dev_d_oe;     // bit1 high lane, bit0 low lane
   logic                    wait_o_n;
   logic                    wait_oe;
   logic                    wait_n;       // resolved wire, pulled high

   assign wait_n = wait_oe ? wait_o_n : 1'b1;

   modport device (
      input  cs_n, mem_sel, addr, upper_write_strobe_n, lower_write_strobe_n,
      input  upper_read_strobe_n, lower_read_strobe_n, host_d,
      output dev_d, dev_d_oe, wait_o_n, wait_oe
   );
   modport host (
      output cs_n, mem_sel, addr, upper_write_strobe_n, lower_write_strobe_n,
      output upper_read_strobe_n, lower_read_strobe_n, host_d, host_d_oe,
      input  dev_d, wait_n
   );
endinterface

// file: design/ssdhp_sync.sv
/*
 two flip-flop synchroniser for a vector of pin levels.
 assumes the pins are asynchronous to clk_i.
*/
`timescale 1ns/1ps
module ssdhp_sync
   import ssdhp_pkg::*;
#(
   parameter int          W    = 1,
   parameter logic [W-1:0] INIT = '0
)(
   // clock and reset
   input  wire logic         clk_i,
   input  wire logic         arst_n_i,
   // levels
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] q_ff;

   // first stage only feeds second stage
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         meta_ff <= INIT;
         q_ff    <= INIT;
      end
      else
      begin
         meta_ff <= d_i;
         q_ff    <= meta_ff;
      end
   end
   assign q_o = q_ff;
endmodule

// file: design/ssdhp_device.sv
/*
 device end of the split strobe port: decodes strobes into byte lanes,
 drives wait and read data, and presents a user-side word access port.
 assumes the user side answers a request with rd/wr done after a few clocks.
*/
`timescale 1ns/1ps
module ssdhp_device
   import ssdhp_pkg::*;
(
   // clock and reset
   input  wire logic                    clk_i,
   input  wire logic                    arst_n_i,
   // static straps
   input  wire logic                    big_endian_i,
   input  wire logic                    wait_mode_i,
   // pins
   ssdhp_bus_if.device                  bus,
   // user side access
   output logic                         req_o,
   output logic                         we_o,
   output logic                         mem_sel_o,
   output logic [SSDHP_ADDR_W:0]        byte_addr_o,
   output logic [1:0]                   byte_en_o,
   output logic [SSDHP_DATA_W-1:0]      wdata_o,
   input  wire logic [SSDHP_DATA_W-1:0] rdata_i,
   input  wire logic                    done_i
);
   typedef enum logic [2:0] {SSDHP_IDLE, SSDHP_BUSY, SSDHP_HOLD} ssdhp_dst_t;

   logic [3:0]              strb_s;
   logic                    cs_n_s;
   logic                    big_ff, nxt_big;
   logic                    waitm_ff, nxt_waitm;
   logic                    strap_ff, nxt_strap;
   ssdhp_dst_t              st_ff, nxt_st;
   logic                    req_ff, nxt_req;
   logic                    we_ff, nxt_we;
   logic                    ms_ff, nxt_ms;
   logic [SSDHP_ADDR_W:0]   ba_ff, nxt_ba;
   logic [1:0]              be_ff, nxt_be;
   logic [SSDHP_DATA_W-1:0] wd_ff, nxt_wd;
   logic [SSDHP_DATA_W-1:0] rd_ff, nxt_rd;
   logic [1:0]              doe_ff, nxt_doe;
   logic                    wt_ff, nxt_wt;
   logic [1:0]              wr_lane, rd_lane;
   logic                    any_wr, any_rd;
   logic [1:0]              lanes;

   // strobe pins pass two flops
   ssdhp_sync #(.W(5), .INIT(5'h1F)) u_sync (
      .clk_i    (clk_i),
      .arst_n_i (arst_n_i),
      .d_i      ({bus.cs_n, bus.upper_write_strobe_n, bus.lower_write_strobe_n,
                  bus.upper_read_strobe_n, bus.lower_read_strobe_n}),
      .q_o      ({cs_n_s, strb_s})
   );

   // decode lanes; mixed strobes are not decoded
   always_comb
   begin
      wr_lane = ~strb_s[3:2];
      rd_lane = ~strb_s[1:0];
      any_wr  = !cs_n_s && (wr_lane != 2'h0) && (rd_lane == 2'h0);
      any_rd  = !cs_n_s && (rd_lane != 2'h0) && (wr_lane == 2'h0);
      lanes   = any_wr ? wr_lane : rd_lane;
   end

   // straps caught once after reset release
   always_comb
   begin
      nxt_strap = 1'b1;
      nxt_big   = strap_ff ? big_ff : big_endian_i;
      nxt_waitm = strap_ff ? waitm_ff : wait_mode_i;
   end

   // access sequencer
   always_comb
   begin
      nxt_st  = st_ff;
      nxt_req = 1'b0;
      nxt_we  = we_ff;
      nxt_ms  = ms_ff;
      nxt_ba  = ba_ff;
      nxt_be  = be_ff;
      nxt_wd  = wd_ff;
      nxt_rd  = rd_ff;
      nxt_doe = doe_ff;
      nxt_wt  = wt_ff;
      unique case (st_ff)
         SSDHP_IDLE:
         begin
            if (any_wr || any_rd)
            begin
               nxt_st  = SSDHP_BUSY;
               nxt_req = 1'b1;
               nxt_we  = any_wr;
               nxt_ms  = bus.mem_sel;
               nxt_ba  = {bus.addr, 1'b0};
               nxt_be  = big_ff ? {lanes[0], lanes[1]} : lanes;
               nxt_wd  = bus.host_d;
               nxt_wt  = waitm_ff;
            end
         end
         SSDHP_BUSY:
         begin
            if (!we_ff)
            begin
               nxt_doe = lanes;
            end
            if (done_i)
            begin
               nxt_st  = SSDHP_HOLD;
               nxt_rd  = rdata_i;
               nxt_wt  = 1'b0;
               if (we_ff)
               begin
                  nxt_wd = bus.host_d;
               end
            end
         end
         SSDHP_HOLD:
         begin
            if (!any_wr && !any_rd)
            begin
               nxt_st  = SSDHP_IDLE;
               nxt_doe = 2'h0;
            end
         end
         default:
         begin
            nxt_st = SSDHP_IDLE;
         end
      endcase
   end

   // registers
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         strap_ff <= 1'b0;
         big_ff   <= SSDHP_LITTLE;
         waitm_ff <= 1'b1;
         st_ff    <= SSDHP_IDLE;
         req_ff   <= 1'b0;
         we_ff    <= 1'b0;
         ms_ff    <= 1'b0;
         ba_ff    <= '0;
         be_ff    <= 2'h0;
         wd_ff    <= '0;
         rd_ff    <= '0;
         doe_ff   <= 2'h0;
         wt_ff    <= 1'b0;
      end
      else
      begin
         strap_ff <= nxt_strap;
         big_ff   <= nxt_big;
         waitm_ff <= nxt_waitm;
         st_ff    <= nxt_st;
         req_ff   <= nxt_req;
         we_ff    <= nxt_we;
         ms_ff    <= nxt_ms;
         ba_ff    <= nxt_ba;
         be_ff    <= nxt_be;
         wd_ff    <= nxt_wd;
         rd_ff    <= nxt_rd;
         doe_ff   <= nxt_doe;
         wt_ff    <= nxt_wt;
      end
   end

   // pin and user outputs
   assign bus.dev_d    = rd_ff;
   assign bus.dev_d_oe = doe_ff;
   assign bus.wait_o_n = 1'b0;
   assign bus.wait_oe  = wt_ff;
   assign req_o        = req_ff;
   assign we_o         = we_ff;
   assign mem_sel_o    = ms_ff;
   assign byte_addr_o  = ba_ff;
   assign byte_en_o    = be_ff;
   assign wdata_o      = wd_ff;
endmodule

// file: design/ssdhp_host.sv
/*
 host end of the split strobe port: runs one access per request,
 keeps strobes exclusive and honours wait or the no-wait stretch.
 assumes the host controller's wait length matches the device's.
*/
`timescale 1ns/1ps
module ssdhp_host
   import ssdhp_pkg::*;
#(
   parameter int WAIT_LEN = SSDHP_WAIT_LEN
)(
   // clock and reset
   input  wire logic                    clk_i,
   input  wire logic                    arst_n_i,
   // static mode
   input  wire logic                    wait_mode_i,
   // pins
   ssdhp_bus_if.host                    bus,
   // request side
   input  wire logic                    req_i,
   input  wire logic                    we_i,
   input  wire logic                    mem_sel_i,
   input  wire logic [SSDHP_ADDR_W-1:0] addr_i,
   input  wire logic [1:0]              lanes_i,
   input  wire logic [SSDHP_DATA_W-1:0] wdata_i,
   output logic                         ready_o,
   output logic                         done_o,
   output logic [SSDHP_DATA_W-1:0]      rdata_o
);
   typedef enum logic [2:0] {SSDHP_H_IDLE, SSDHP_H_SETUP, SSDHP_H_STRB,
                             SSDHP_H_END} ssdhp_hst_t;
   localparam logic [SSDHP_CNT_W-1:0] WR_CYC =
      SSDHP_CNT_W'(WAIT_LEN + SSDHP_WR_EXTRA);
   localparam logic [SSDHP_CNT_W-1:0] RD_CYC =
      SSDHP_CNT_W'(WAIT_LEN + SSDHP_RD_EXTRA_CYC + 1);

   logic                    wait_s;
   ssdhp_hst_t              st_ff, nxt_st;
   logic [SSDHP_CNT_W-1:0]  cnt_ff, nxt_cnt;
   logic                    cs_ff, nxt_cs;
   logic                    we_ff, nxt_we;
   logic                    ms_ff, nxt_ms;
   logic [SSDHP_ADDR_W-1:0] ad_ff, nxt_ad;
   logic [1:0]              ln_ff, nxt_ln;
   logic                    sa_ff, nxt_sa;
   logic [SSDHP_DATA_W-1:0] wd_ff, nxt_wd;
   logic [SSDHP_DATA_W-1:0] rd_ff, nxt_rd;
   logic                    dn_ff, nxt_dn;
   logic                    seen_ff, nxt_seen;

   ssdhp_sync #(.W(1), .INIT(1'h1)) u_wsync (
      .clk_i    (clk_i),
      .arst_n_i (arst_n_i),
      .d_i      (bus.wait_n),
      .q_o      (wait_s)
   );

   // access sequencer
   always_comb
   begin
      nxt_st   = st_ff;
      nxt_cnt  = cnt_ff;
      nxt_cs   = cs_ff;
      nxt_we   = we_ff;
      nxt_ms   = ms_ff;
      nxt_ad   = ad_ff;
      nxt_ln   = ln_ff;
      nxt_sa   = 1'b0;
      nxt_wd   = wd_ff;
      nxt_rd   = rd_ff;
      nxt_dn   = 1'b0;
      nxt_seen = seen_ff;
      unique case (st_ff)
         SSDHP_H_IDLE:
         begin
            if (req_i && (lanes_i != 2'h0))
            begin
               nxt_st = SSDHP_H_SETUP;
               nxt_cs = 1'b1;
               nxt_we = we_i;
               nxt_ms = mem_sel_i;
               nxt_ad = addr_i;
               nxt_ln = lanes_i;
               nxt_wd = wdata_i;
            end
         end
         SSDHP_H_SETUP:
         begin
            nxt_st   = SSDHP_H_STRB;
            nxt_sa   = 1'b1;
            nxt_cnt  = '0;
            nxt_seen = 1'b0;
         end
         SSDHP_H_STRB:
         begin
            nxt_sa  = 1'b1;
            nxt_cnt = cnt_ff + 1'b1;
            if (!wait_s)
            begin
               nxt_seen = 1'b1;
            end
            if (wait_mode_i)
            begin
               if (seen_ff && wait_s)
               begin
                  nxt_st = SSDHP_H_END;
                  nxt_sa = 1'b0;
                  nxt_rd = bus.dev_d;
               end
            end
            else if (cnt_ff >= (we_ff ? WR_CYC : RD_CYC))
            begin
               nxt_st = SSDHP_H_END;
               nxt_sa = 1'b0;
               nxt_rd = bus.dev_d;
            end
         end
         SSDHP_H_END:
         begin
            nxt_st = SSDHP_H_IDLE;                         // cs held past rise
            nxt_cs = 1'b0;
            nxt_dn = 1'b1;
         end
         default:
         begin
            nxt_st = SSDHP_H_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         st_ff   <= SSDHP_H_IDLE;
         cnt_ff  <= '0;
         cs_ff   <= 1'b0;
         we_ff   <= 1'b0;
         ms_ff   <= 1'b0;
         ad_ff   <= '0;
         ln_ff   <= 2'h0;
         sa_ff   <= 1'b0;
         wd_ff   <= '0;
         rd_ff   <= '0;
         dn_ff   <= 1'b0;
         seen_ff <= 1'b0;
      end
      else
      begin
         st_ff   <= nxt_st;
         cnt_ff  <= nxt_cnt;
         cs_ff   <= nxt_cs;
         we_ff   <= nxt_we;
         ms_ff   <= nxt_ms;
         ad_ff   <= nxt_ad;
         ln_ff   <= nxt_ln;
         sa_ff   <= nxt_sa;
         wd_ff   <= nxt_wd;
         rd_ff   <= nxt_rd;
         dn_ff   <= nxt_dn;
         seen_ff <= nxt_seen;
      end
   end

   // strobes: only one direction ever active
   assign bus.upper_write_strobe_n = !(sa_ff && we_ff && ln_ff[1]);
   assign bus.lower_write_strobe_n = !(sa_ff && we_ff && ln_ff[0]);
   assign bus.upper_read_strobe_n  = !(sa_ff && !we_ff && ln_ff[1]);
   assign bus.lower_read_strobe_n  = !(sa_ff && !we_ff && ln_ff[0]);
   assign bus.cs_n      = !cs_ff;
   assign bus.mem_sel   = ms_ff;
   assign bus.addr      = ad_ff;
   assign bus.host_d    = wd_ff;
   assign bus.host_d_oe = cs_ff && we_ff;
   assign ready_o       = (st_ff == SSDHP_H_IDLE);
   assign done_o        = dn_ff;
   assign rdata_o       = rd_ff;
endmodule

// file: testbench/ssdhp_bus_chk.sv
/*
 checker on the host port pins: strobe exclusivity, select and address
 hold, wait and lane timing, no-wait cycle length.
 assumes it sits beside the interface joining host and device ends.
*/
`timescale 1ns/1ps
module ssdhp_bus_chk
   import ssdhp_pkg::*;
#(
   parameter int WAIT_LEN = SSDHP_WAIT_LEN
)(
   // clock, reset and mode
   input wire logic                    clk_i,
   input wire logic                    arst_n_i,
   input wire logic                    wait_mode_i,
   // host driven pins
   input wire logic                    cs_n,
   input wire logic                    mem_sel,
   input wire logic [SSDHP_ADDR_W-1:0] addr,
   input wire logic                    upper_write_strobe_n,
   input wire logic                    lower_write_strobe_n,
   input wire logic                    upper_read_strobe_n,
   input wire logic                    lower_read_strobe_n,
   // device driven pins
   input wire logic [1:0]              dev_d_oe,
   input wire logic                    wait_n
);
   logic                   any_wr;
   logic                   any_rd;
   logic                   any_stb;
   logic [SSDHP_CNT_W-1:0] wr_cnt_ff;
   logic [SSDHP_CNT_W-1:0] rd_cnt_ff;
   logic [SSDHP_CNT_W-1:0] nxt_wr_cnt;
   logic [SSDHP_CNT_W-1:0] nxt_rd_cnt;

   // strobe groups
   assign any_wr  = !upper_write_strobe_n || !lower_write_strobe_n;
   assign any_rd  = !upper_read_strobe_n || !lower_read_strobe_n;
   assign any_stb = any_wr || any_rd;

   // cycles a strobe group has been low
   always_comb
   begin
      nxt_wr_cnt = any_wr ? wr_cnt_ff + 8'h01 : 8'h00;
      nxt_rd_cnt = any_rd ? rd_cnt_ff + 8'h01 : 8'h00;
   end

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         wr_cnt_ff <= 8'h00;
         rd_cnt_ff <= 8'h00;
      end
      else
      begin
         wr_cnt_ff <= nxt_wr_cnt;
         rd_cnt_ff <= nxt_rd_cnt;
      end
   end

   default clocking @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);

   AST_STB_EXCL: assert property (!(any_wr && any_rd))
      else $error("write and read strobes low together");
   AST_CS_SETUP: assert property ($rose(any_stb) |-> $past(cs_n) == 1'b0)
      else $error("strobe fell without prior chip select");
   AST_ADDR_HOLD: assert property (any_stb && $past(any_stb)
      |-> !cs_n && $stable(addr) && $stable(mem_sel))
      else $error("select or address moved under a strobe");
   AST_CS_HOLD: assert property ($fell(any_stb) |-> !cs_n && $stable(addr))
      else $error("select or address released with the strobe");
   AST_WAIT_WR: assert property (wait_mode_i && $rose(any_wr) |-> ##[1:4] !wait_n)
      else $error("wait not driven low after write strobe");
   AST_WAIT_RD: assert property (wait_mode_i && $rose(any_rd) |-> ##[1:4] !wait_n)
      else $error("wait not driven low after read strobe");
   AST_IDLE_REL: assert property ((!any_stb) [*6] |-> wait_n && dev_d_oe == 2'h0)
      else $error("wait or data still driven while idle");
   AST_RD_LANES: assert property ($fell(any_stb) && $past(any_rd) |->
      dev_d_oe == ~{$past(upper_read_strobe_n), $past(lower_read_strobe_n)})
      else $error("driven lanes differ from read strobes");
   AST_WR_NO_OE: assert property (any_wr [*4] |-> dev_d_oe == 2'h0)
      else $error("device drives data during a write");
   AST_WR_LEN: assert property (!wait_mode_i && $fell(any_wr)
      |-> wr_cnt_ff >= WAIT_LEN + SSDHP_WR_EXTRA)
      else $error("no-wait write strobe too short");
   AST_RD_LEN: assert property (!wait_mode_i && $fell(any_rd)
      |-> rd_cnt_ff >= WAIT_LEN + SSDHP_RD_EXTRA_CYC)
      else $error("no-wait read strobe too short");

   // main scenarios
   cover property (wait_mode_i && $fell(any_wr));
   cover property (!wait_mode_i && $fell(any_rd));
   cover property ($fell(wait_n));
endmodule

// file: testbench/test_split_strobe_direct_host_port.sv
/*
 testbench: host and device ends joined by one interface; writes and
 reads of every lane set in both byte orders and both wait modes, plus
 a second device fed mixed strobes. assumes a 40 MHz clk_i.
*/
`timescale 1ns/1ps
module test_split_strobe_direct_host_port
   import ssdhp_pkg::*;
;
   localparam int WL = SSDHP_WAIT_LEN;
   logic        clk_i = 1'h0, arst_n_i = 1'h0, big = 1'h0, wm = 1'h0;
   logic        h_req = 1'h0, h_we = 1'h0, h_ms = 1'h0, h_rdy, h_done;
   logic [1:0]  h_ln = 2'h1, d_be, c_be;
   logic [16:0] h_a = 17'h00000;
   logic [15:0] h_wd = 16'h0000, h_rd, d_rd = 16'h0000, rd_word, d_wd, c_wd;
   logic        d_req, d_we, d_ms, d_done = 1'h0, d2_req, c_we, c_ms;
   logic [17:0] d_ba, c_ba;
   logic [3:0]  reqs;
   int          err_count = 0, total_checks = 0, cyc = 0;

   ssdhp_bus_if bus ();
   ssdhp_bus_if bus2 ();
   ssdhp_host #(.WAIT_LEN(WL)) ssdhp_host_inst (.clk_i(clk_i), .arst_n_i(arst_n_i),
      .wait_mode_i(wm), .bus(bus), .req_i(h_req), .we_i(h_we), .mem_sel_i(h_ms),
      .addr_i(h_a), .lanes_i(h_ln), .wdata_i(h_wd), .ready_o(h_rdy), .done_o(h_done),
      .rdata_o(h_rd));
   ssdhp_device ssdhp_device_inst (.clk_i(clk_i), .arst_n_i(arst_n_i), .big_endian_i(big),
      .wait_mode_i(wm), .bus(bus), .req_o(d_req), .we_o(d_we), .mem_sel_o(d_ms),
      .byte_addr_o(d_ba), .byte_en_o(d_be), .wdata_o(d_wd), .rdata_i(d_rd), .done_i(d_done));
   ssdhp_device ssdhp_device_inst2 (.clk_i(clk_i), .arst_n_i(arst_n_i), .big_endian_i(1'h0),
      .wait_mode_i(1'h1), .bus(bus2), .req_o(d2_req), .we_o(), .mem_sel_o(),
      .byte_addr_o(), .byte_en_o(), .wdata_o(), .rdata_i(16'h0000), .done_i(1'h0));
   ssdhp_bus_chk #(.WAIT_LEN(WL)) ssdhp_bus_chk_inst (.clk_i(clk_i), .arst_n_i(arst_n_i),
      .wait_mode_i(wm), .cs_n(bus.cs_n), .mem_sel(bus.mem_sel), .addr(bus.addr),
      .upper_write_strobe_n(bus.upper_write_strobe_n),
      .lower_write_strobe_n(bus.lower_write_strobe_n),
      .upper_read_strobe_n(bus.upper_read_strobe_n),
      .lower_read_strobe_n(bus.lower_read_strobe_n), .dev_d_oe(bus.dev_d_oe),
      .wait_n(bus.wait_n));

   // clock and hang guard
   always #12.5 clk_i = ~clk_i;
   always @(posedge clk_i)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         err_count++;
         final_report;
      end
   end

   task automatic final_report;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // user side of the device: stale data until the answer, slow in wait mode
   initial forever
   begin
      @(posedge clk_i);
      #1;
      if (d_req === 1'h1)
      begin
         {c_we, c_ms, c_ba, c_be} = {d_we, d_ms, d_ba, d_be};
         reqs++;
         d_rd = ~rd_word;
         repeat (wm ? 5 : 0) @(posedge clk_i);
         #1 d_rd = rd_word;
         d_done = 1'h1;
         @(posedge clk_i);
         #1 c_wd = d_wd;
         d_done = 1'h0;
      end
   end

   // straps are taken at the first edge after release
   task automatic rst(input logic b, input logic w);
      {big, wm} = {b, w};
      arst_n_i = 1'h0;
      repeat (4) @(posedge clk_i);
      #1 arst_n_i = 1'h1;
   endtask

   // one host access, then compare both user sides
   task automatic acc(input logic we, input logic [16:0] a, input logic [1:0] l,
                      input logic [15:0] wd);
      logic [15:0] m;
      int          n;
      m = {{8{l[1]}}, {8{l[0]}}};
      chk(h_rdy, 1'h1);
      {h_req, h_we, h_ms, h_a, h_ln, h_wd} = {1'h1, we, a[0], a, l, wd};
      rd_word = wd;
      reqs = 4'h0;
      @(posedge clk_i);
      #1 h_req = 1'h0;
      n = 0;
      while (h_done !== 1'h1 && n < 200)
      begin
         @(posedge clk_i);
         #1 n++;
      end
      chk(h_done, 1'h1);
      chk(c_be, big ? {l[0], l[1]} : l);
      chk(c_ba, {a, 1'h0});
      chk({c_we, c_ms, reqs}, {we, a[0], 4'h1});
      if (we) chk(c_wd & m, wd & m);
      else chk(h_rd & m, wd & m);
   endtask

   initial
   begin
      {bus2.cs_n, bus2.mem_sel, bus2.upper_write_strobe_n} = 3'h5;
      {bus2.lower_write_strobe_n, bus2.upper_read_strobe_n, bus2.lower_read_strobe_n} = 3'h7;
      {bus2.addr, bus2.host_d, bus2.host_d_oe} = '0;
      for (int k = 0; k < 4; k++)
      begin
         rst(k[1], k[0]);
         for (int j = 1; j < 4; j++)
         begin
            acc(1'h1, (j == 2) ? 17'h00000 : {j[1:0], 15'h7FFF}, j[1:0],
                16'hC35A ^ {k[7:0], j[7:0]});
            acc(1'h0, (j == 2) ? 17'h00000 : {j[1:0], 15'h7FFF}, j[1:0],
                16'h3CA5 ^ {j[7:0], k[7:0]});
         end
      end
      // mixed write and read strobes on the second device
      {bus2.cs_n, bus2.upper_write_strobe_n, bus2.lower_read_strobe_n} = 3'h0;
      repeat (10)
      begin
         @(posedge clk_i);
         #1 chk({d2_req, bus2.wait_n}, 2'h1);
      end
      final_report;
   end
endmodule
